// ---- ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ctl_model (
  input  wire logic                             mclk,
  input  wire logic                             rstn,
  output logic                                  in_clock_run,
  output logic                                  out_timing_pos,
  output logic                                  out_timing_neg,
  output logic                                  lock_loop_disable_n,
  output logic                                  load_strobe_n,
  output logic                                  read_not_write,
  output logic [sram_port_pkg::ADDR_W-1:0]      address,
  output logic [sram_port_pkg::WORD_W-1:0]      write_bus,
  output logic                                  lane_lo_write_sel_n,
  output logic                                  lane_hi_write_sel_n
);
  logic nxt_pos;
  logic strap_hi;

  // phase of the coming edge; frozen while the clocks stand still
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) nxt_pos <= 1'b1;
    else if (in_clock_run) nxt_pos <= !nxt_pos;
  end

  // complementary at the first edge, so the single clock strap stays off
  assign out_timing_pos = nxt_pos || strap_hi;
  assign out_timing_neg = !nxt_pos || strap_hi;

  initial begin
    strap_hi = 1'b0;
    in_clock_run = 1'b1;
    lock_loop_disable_n = 1'b1;
    load_strobe_n = 1'b1;
    read_not_write = 1'b0;
    address = 21'h000000;
    write_bus = 18'h00000;
    lane_lo_write_sel_n = 1'b1;
    lane_hi_write_sel_n = 1'b1;
  end

  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  task automatic cmd(input logic rnw, input logic [20:0] a);
    while (!nxt_pos) step();
    load_strobe_n = 1'b0;
    read_not_write = rnw;
    address = a;
    step();
    load_strobe_n = 1'b1;
    // released lines carry garbage, never the old value
    read_not_write = !rnw;
    address = ~a;
  endtask

  task automatic wr(input logic [20:0] a, input logic [17:0] d0,
                    input logic [1:0] m0, input logic [17:0] d1,
                    input logic [1:0] m1);
    cmd(1'b0, a);
    step();
    write_bus = d0;
    {lane_hi_write_sel_n, lane_lo_write_sel_n} = m0;
    step();
    write_bus = d1;
    {lane_hi_write_sel_n, lane_lo_write_sel_n} = m1;
    step();
    write_bus = ~d1;
    {lane_hi_write_sel_n, lane_lo_write_sel_n} = ~m1;
  endtask

  task automatic halt(input int n);
    in_clock_run = 1'b0;
    repeat (n) step();
    in_clock_run = 1'b1;
  endtask

  // both output clocks high through reset release selects single mode
  task automatic strap(input logic v);
    strap_hi = v;
  endtask

  task automatic loop_en(input logic v);
    lock_loop_disable_n = v;
  endtask
endmodule
`default_nettype wire

// ---- sram_port.sv ----
// How it works
// - write: command at edge t, data at pos edge t+1 and next neg edge
// - read: word0 at neg rise in t+1, word1 at pos rise in t+2
// - burst touches latched address then the next location, two words
// - active-low lane selects gate bits 8:0 and 17:9; others unaltered
// - both selects high writes nothing for that half
// - each data half uses its own sampled lane selects
// - after reset deselected with read_bus tristated
// - read data launched on input pair edges in every mode, output clock pair unused
// - free-running echo clocks follow the output clock pair
// - single clock mode echoes derive from the input clock pair
// - lock reported a fixed time after stable clock with loop enabled
// - clock stopped at least the minimum interval resets the lock
// - loop disabled gives one-cycle read latency mode
// - with no read, finish pending bursts then tristate after pos rise
// - a write is posted in holding registers, committed on next write
`timescale 1ns/1ps
`default_nettype none
module sram_port (
  input  wire logic                              mclk,
  input  wire logic                              rstn,
  input  wire logic                              in_clock_run,
  input  wire logic                              out_timing_pos,
  input  wire logic                              out_timing_neg,
  input  wire logic                              lock_loop_disable_n,
  input  wire logic                              load_strobe_n,
  input  wire logic                              read_not_write,
  input  wire logic [sram_port_pkg::ADDR_W-1:0]  address,
  input  wire logic [sram_port_pkg::WORD_W-1:0]  write_bus,
  input  wire logic                              lane_lo_write_sel_n,
  input  wire logic                              lane_hi_write_sel_n,
  output logic      [sram_port_pkg::WORD_W-1:0]  read_bus,
  output logic                                   read_bus_oe,
  output logic                                   echo_strobe_pos,
  output logic                                   echo_strobe_neg,
  output logic                                   pll_locked
);
  localparam int AW = sram_port_pkg::ADDR_W;
  localparam int DW = sram_port_pkg::WORD_W;
  localparam int LW = sram_port_pkg::LANE_W;
  localparam int NL = sram_port_pkg::LANES;
  localparam int CW = sram_port_pkg::CNT_W;

  logic [DW-1:0] mem [sram_port_pkg::MEM_DEPTH];

  sram_port_pkg::phase_t phase_q;
  logic          run;
  logic          ddr1;
  logic          single_q;
  logic          strap_done_q;
  logic          rd_v0_q, rd_v1_q, wr_v0_q, wr_v1_q;
  logic [AW-1:0] rd_a0_q, rd_a1_q, wr_a0_q, wr_a1_q;
  logic [DW-1:0] st_d0_q;
  logic [NL-1:0] st_m0_q;
  logic          hold_v_q;
  logic [AW-1:0] hold_a_q;
  logic [DW-1:0] hold_d0_q, hold_d1_q;
  logic [NL-1:0] hold_m0_q, hold_m1_q;
  logic [NL-1:0] in_mask;
  logic [CW-1:0] lock_cnt_q, stop_cnt_q;
  logic          is_pos;
  logic          commit;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  assign run     = in_clock_run;
  assign ddr1    = ~lock_loop_disable_n;
  assign is_pos  = (phase_q == sram_port_pkg::PH_POS);
  assign in_mask = {~lane_hi_write_sel_n, ~lane_lo_write_sel_n};
  assign commit  = run && !is_pos && wr_v1_q;

  function automatic logic [DW-1:0] merge(
    input logic [DW-1:0] old_w,
    input logic [DW-1:0] new_w,
    input logic [NL-1:0] mask
  );
    logic [DW-1:0] res;
    res = old_w;
    for (int i = 0; i < NL; i++) begin
      if (mask[i]) begin
        res[i*LW +: LW] = new_w[i*LW +: LW];
      end
    end
    return res;
  endfunction

  // array word with any posted write laid over it
  function automatic logic [DW-1:0] fetch(
    input logic [AW-1:0] a,
    input logic          half
  );
    logic [DW-1:0] w;
    w = mem[{a, half}];
    if (hold_v_q && hold_a_q == a) begin
      w = (half == sram_port_pkg::HALF_LO)
          ? merge(w, hold_d0_q, hold_m0_q)
          : merge(w, hold_d1_q, hold_m1_q);
    end
    return w;
  endfunction

  // stopped clock freezes every stage but the strap capture and the stop and lock timers, so outputs other than pll_locked keep their state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= sram_port_pkg::PH_POS;
    end else if (run) begin
      phase_q <= is_pos ? sram_port_pkg::PH_NEG : sram_port_pkg::PH_POS;
    end
  end

  // strap caught on the first edge after release, then frozen
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      single_q     <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      single_q     <= out_timing_pos && out_timing_neg;
      strap_done_q <= 1'b1;
    end
  end

  // command pipeline, advanced on pos edges only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_v0_q <= 1'b0;
      rd_v1_q <= 1'b0;
      wr_v0_q <= 1'b0;
      wr_v1_q <= 1'b0;
      rd_a0_q <= sram_port_pkg::ADDR_ZERO;
      rd_a1_q <= sram_port_pkg::ADDR_ZERO;
      wr_a0_q <= sram_port_pkg::ADDR_ZERO;
      wr_a1_q <= sram_port_pkg::ADDR_ZERO;
    end else if (run && is_pos) begin
      rd_v0_q <= !load_strobe_n && read_not_write;
      wr_v0_q <= !load_strobe_n && !read_not_write;
      rd_a0_q <= address;
      wr_a0_q <= address;
      rd_v1_q <= rd_v0_q;
      wr_v1_q <= wr_v0_q;
      rd_a1_q <= rd_a0_q;
      wr_a1_q <= wr_a0_q;
    end
  end

  // first data half staged at pos edge of t+1 with its own selects
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_d0_q <= sram_port_pkg::WORD_ZERO;
      st_m0_q <= sram_port_pkg::MASK_NONE;
    end else if (run && is_pos && wr_v0_q) begin
      st_d0_q <= write_bus;
      st_m0_q <= in_mask;
    end
  end

  // second half completes the write; the earlier posted one is retired
  // so a read never collides with an array write of the same burst
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hold_v_q  <= 1'b0;
      hold_a_q  <= sram_port_pkg::ADDR_ZERO;
      hold_d0_q <= sram_port_pkg::WORD_ZERO;
      hold_d1_q <= sram_port_pkg::WORD_ZERO;
      hold_m0_q <= sram_port_pkg::MASK_NONE;
      hold_m1_q <= sram_port_pkg::MASK_NONE;
    end else if (commit) begin
      hold_v_q  <= 1'b1;
      hold_a_q  <= wr_a1_q;
      hold_d0_q <= st_d0_q;
      hold_d1_q <= write_bus;
      hold_m0_q <= st_m0_q;
      hold_m1_q <= in_mask;
    end
  end

  // array has no reset; masked lanes keep contents
  always_ff @(posedge mclk) begin
    if (commit && hold_v_q) begin
      mem[{hold_a_q, sram_port_pkg::HALF_LO}] <=
        merge(mem[{hold_a_q, sram_port_pkg::HALF_LO}],
              hold_d0_q, hold_m0_q);
      mem[{hold_a_q, sram_port_pkg::HALF_HI}] <=
        merge(mem[{hold_a_q, sram_port_pkg::HALF_HI}],
              hold_d1_q, hold_m1_q);
    end
  end

  // read launch: loop on gives word0 on the neg rise of t+1 and word1
  // on the pos rise of t+2; loop off is half a cycle earlier, pos rise then neg rise of t+1
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      read_bus    <= sram_port_pkg::WORD_ZERO;
      read_bus_oe <= 1'b0;
    end else if (run) begin
      if (is_pos) begin
        if (ddr1 && rd_v0_q) begin
          read_bus    <= fetch(rd_a0_q, sram_port_pkg::HALF_LO);
          read_bus_oe <= 1'b1;
        end else if (!ddr1 && rd_v1_q) begin
          read_bus    <= fetch(rd_a1_q, sram_port_pkg::HALF_HI);
          read_bus_oe <= 1'b1;
        end else begin
          read_bus_oe <= 1'b0;
        end
      end else if (rd_v1_q) begin
        read_bus    <= fetch(rd_a1_q, ddr1);
        read_bus_oe <= 1'b1;
      end
    end
  end

  // echoes: output clock pair normally, internal phase in single mode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      echo_strobe_pos <= 1'b0;
      echo_strobe_neg <= 1'b0;
    end else if (run) begin
      if (single_q) begin
        echo_strobe_pos <= is_pos;
        echo_strobe_neg <= !is_pos;
      end else begin
        echo_strobe_pos <= out_timing_pos;
        echo_strobe_neg <= out_timing_neg;
      end
    end
  end

  // lock timer; a long enough stop restarts it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stop_cnt_q <= sram_port_pkg::CNT_ZERO;
    end else if (run) begin
      stop_cnt_q <= sram_port_pkg::CNT_ZERO;
    end else if (stop_cnt_q != sram_port_pkg::STOP_CNT) begin
      stop_cnt_q <= stop_cnt_q + sram_port_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lock_cnt_q <= sram_port_pkg::CNT_ZERO;
      pll_locked <= 1'b0;
    end else if (!lock_loop_disable_n ||
                 stop_cnt_q == sram_port_pkg::STOP_CNT) begin
      lock_cnt_q <= sram_port_pkg::CNT_ZERO;
      pll_locked <= 1'b0;
    end else if (run) begin
      if (lock_cnt_q == sram_port_pkg::LOCK_CNT) begin
        pll_locked <= 1'b1;
      end else begin
        lock_cnt_q <= lock_cnt_q + sram_port_pkg::CNT_ONE;
      end
    end
  end

  sequence s_rd_cmd;
    run && is_pos && !load_strobe_n && read_not_write && lock_loop_disable_n;
  endsequence
  sequence s_steady_run; (run && lock_loop_disable_n) [*3]; endsequence
  a_read_latency_two: assert property (
    s_rd_cmd ##1 s_steady_run |=> read_bus_oe ##1 read_bus_oe)
    else $error("read burst not driven at expected edges");
  a_read_first_word: assert property (
    s_rd_cmd ##1 s_steady_run |-> !is_pos ##1 read_bus_oe)
    else $error("first read word not on neg phase");
  a_ddr1_latency: assert property (
    run && is_pos && !load_strobe_n && read_not_write && !lock_loop_disable_n
    ##1 (run && !lock_loop_disable_n) [*2] |=> read_bus_oe)
    else $error("loop-off read not one cycle latency");
  a_idle_tristate: assert property (
    run && is_pos && !rd_v0_q && !rd_v1_q ##1 run |=> !read_bus_oe)
    else $error("read bus still driven with no read");
  a_stop_holds_out: assert property (
    !run |=> $stable(read_bus) && $stable(read_bus_oe))
    else $error("outputs moved while clock stopped");
  a_posted_commit: assert property (
    commit |=> hold_v_q && hold_a_q == $past(wr_a1_q))
    else $error("posted write not captured");
  a_lock_reset: assert property (
    stop_cnt_q == sram_port_pkg::STOP_CNT |=> !pll_locked)
    else $error("lock kept after long clock stop");
  a_lock_needs_time: assert property (
    $rose(pll_locked) |-> $past(lock_cnt_q) == sram_port_pkg::LOCK_CNT)
    else $error("lock reported early");
  a_single_echo: assert property (
    single_q && run |=> echo_strobe_pos == $past(is_pos))
    else $error("single mode echo not derived from input pair");
  a_echo_follows: assert property (
    strap_done_q && !single_q && run
    |=> echo_strobe_pos == $past(out_timing_pos))
    else $error("echo does not follow output clock");
  a_hit_returns_post: assert property (
    run && !is_pos && rd_v1_q && !ddr1 && hold_v_q && hold_a_q == rd_a1_q
    && hold_m0_q == 2'h3 && !commit |=> read_bus == $past(hold_d0_q))
    else $error("read missed posted data");
endmodule
`default_nettype wire

// ---- sram_port_pkg.sv ----
package sram_port_pkg;
  localparam int ADDR_W     = 21;
  localparam int WORD_W     = 18;
  localparam int LANE_W     = 9;
  localparam int LANES      = 2;
  localparam int MEM_AW     = ADDR_W + 1;
  localparam int MEM_DEPTH  = 1 << MEM_AW;
  localparam int CLK_PS     = 5000;
  localparam int LOCK_US    = 20;
  localparam int LOCK_CYC   = (LOCK_US * 1000000) / CLK_PS;
  localparam int STOP_NS    = 30;
  localparam int STOP_CYC   = (STOP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W      = 12;
  localparam logic [CNT_W-1:0] LOCK_CNT = CNT_W'(LOCK_CYC);
  localparam logic [CNT_W-1:0] STOP_CNT = CNT_W'(STOP_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 12'h001;
  localparam logic [WORD_W-1:0] WORD_ZERO = 18'h00000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 21'h000000;
  localparam logic [LANES-1:0]  MASK_NONE = 2'h0;
  localparam logic              HALF_LO   = 1'b0;
  localparam logic              HALF_HI   = 1'b1;

  // edge phase: each mclk edge is alternately an in_timing_pos rise
  // and its complementary rise
  typedef enum logic [1:0] {
    PH_POS = 2'b01,
    PH_NEG = 2'b10
  } phase_t;
endpackage

// ---- sram_port_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module sram_port_tb;
  localparam int LIMIT = 6000;
  localparam int LOCK  = sram_port_pkg::LOCK_CYC;
  logic        mclk, rstn, in_clock_run, out_timing_pos, out_timing_neg;
  logic        lock_loop_disable_n, load_strobe_n, read_not_write;
  logic [20:0] address;
  logic [17:0] write_bus, read_bus;
  logic        lane_lo_write_sel_n, lane_hi_write_sel_n, read_bus_oe;
  logic        echo_strobe_pos, echo_strobe_neg, pll_locked;
  logic [17:0] mem [int];
  int          failures = 0;
  int          num_checks = 0;
  int          cycles = 0;

  sram_port uut (
    .mclk, .rstn, .in_clock_run, .out_timing_pos, .out_timing_neg,
    .lock_loop_disable_n, .load_strobe_n, .read_not_write, .address,
    .write_bus, .lane_lo_write_sel_n, .lane_hi_write_sel_n, .read_bus,
    .read_bus_oe, .echo_strobe_pos, .echo_strobe_neg, .pll_locked
  );
  ctl_model ctl (
    .mclk, .rstn, .in_clock_run, .out_timing_pos, .out_timing_neg,
    .lock_loop_disable_n, .load_strobe_n, .read_not_write, .address,
    .write_bus, .lane_lo_write_sel_n, .lane_hi_write_sel_n
  );

  initial mclk = 1'b0;
  always #2.5 mclk = !mclk;

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures = failures + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_w(input logic [17:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s %b not %b", $time, what, got, exp);
    end
  endtask

  // active-low selects: m[0] lanes 8:0, m[1] lanes 17:9
  function automatic logic [17:0] merge(logic [17:0] o, d, logic [1:0] m);
    if (!m[0]) o[8:0] = d[8:0];
    if (!m[1]) o[17:9] = d[17:9];
    return o;
  endfunction

  task automatic write_burst(input logic [20:0] a, input logic [17:0] d0,
                             input logic [1:0] m0, input logic [17:0] d1,
                             input logic [1:0] m1);
    int k0;
    int k1;
    k0 = int'({a, 1'b0});
    k1 = int'({a, 1'b1});
    mem[k0] = merge(mem.exists(k0) ? mem[k0] : d0, d0, m0);
    mem[k1] = merge(mem.exists(k1) ? mem[k1] : d1, d1, m1);
    ctl.wr(a, d0, m0, d1, m1);
  endtask

  // two back-to-back reads, then idle until the bus is released
  task automatic read_pair(input logic [20:0] a, b, input int lat);
    ctl.cmd(1'b1, a);
    ctl.cmd(1'b1, b);
    repeat (lat - 2) ctl.step();
    chk_w(read_bus, mem[int'({a, 1'b0})], "a word0");
    chk_b(read_bus_oe, 1'b1, "oe on");
    ctl.step();
    chk_w(read_bus, mem[int'({a, 1'b1})], "a word1");
    ctl.step();
    chk_w(read_bus, mem[int'({b, 1'b0})], "b word0");
    ctl.step();
    chk_w(read_bus, mem[int'({b, 1'b1})], "b word1");
    repeat (2) ctl.step();
    chk_b(read_bus_oe, 1'b0, "oe off");
  endtask

  task automatic t_lock();
    int n;
    repeat (LOCK - 8) ctl.step();
    chk_b(pll_locked, 1'b0, "early lock");
    n = 0;
    while (pll_locked !== 1'b1 && n < 16) begin
      ctl.step();
      n++;
    end
    chk_b(pll_locked, 1'b1, "lock");
    $display("test lock done");
  endtask

  task automatic t_echo();
    logic prev;
    prev = echo_strobe_pos;
    repeat (4) begin
      ctl.step();
      chk_b(echo_strobe_pos, !prev, "echo toggle");
      chk_b(echo_strobe_neg, prev, "echo pair");
      prev = echo_strobe_pos;
    end
    $display("test echo done");
  endtask

  task automatic t_rw();
    write_burst(21'h000010, 18'h2A5C3, 2'h0, 18'h15A3C, 2'h0);
    write_burst(21'h1FFFFF, 18'h3FFFF, 2'h0, 18'h00001, 2'h0);
    read_pair(21'h000010, 21'h1FFFFF, 3);
    $display("test read write done");
  endtask

  task automatic t_lanes();
    write_burst(21'h000010, 18'h0F0F0, 2'h2, 18'h33333, 2'h3);
    write_burst(21'h1FFFFF, 18'h12345, 2'h1, 18'h2AAAA, 2'h0);
    read_pair(21'h000010, 21'h1FFFFF, 3);
    $display("test lanes done");
  endtask

  task automatic t_stop();
    ctl.cmd(1'b1, 21'h000010);
    repeat (3) ctl.step();
    ctl.halt(8);
    chk_w(read_bus, mem[32], "held word");
    chk_b(read_bus_oe, 1'b1, "held oe");
    ctl.step();
    chk_w(read_bus, mem[33], "resumed word");
    chk_b(pll_locked, 1'b0, "lock lost");
    repeat (4) ctl.step();
    $display("test stop done");
  endtask

  task automatic t_loopoff();
    ctl.loop_en(1'b0);
    ctl.step();
    read_pair(21'h1FFFFF, 21'h000010, 2);
    $display("test loop off done");
  endtask

  // mid-run reset with the strap held, then echoes from the input pair
  task automatic t_single();
    rstn = 1'b0;
    ctl.strap(1'b1);
    ctl.step();
    rstn = 1'b1;
    repeat (2) ctl.step();
    repeat (2) begin
      chk_b(echo_strobe_pos, 1'b0, "single echo neg");
      chk_b(echo_strobe_neg, 1'b1, "single echo neg pair");
      ctl.step();
      chk_b(echo_strobe_pos, 1'b1, "single echo pos");
      chk_b(echo_strobe_neg, 1'b0, "single echo pos pair");
      ctl.step();
    end
    $display("test single clock done");
  endtask

  initial begin
    rstn = 1'b0;
    repeat (16) @(posedge mclk);
    #1;
    chk_b(read_bus_oe, 1'b0, "reset oe");
    chk_w(read_bus, 18'h00000, "reset bus");
    chk_b(pll_locked, 1'b0, "reset lock");
    rstn = 1'b1;
    t_lock();
    t_echo();
    t_rw();
    t_lanes();
    t_stop();
    t_loopoff();
    t_single();
    end_sim();
  end
endmodule
`default_nettype wire
